//--- hw/serial_rate_gen.sv
// half-period tick generator for the internal serial clock
`timescale 1ns/10ps
`include "sync_serial_defines.svh"
module serial_rate_gen (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [2:0] clkSel,
  input wire logic lowClockSel,
  input wire logic extraDiv,
  input wire logic lowSpeed,
  input wire logic subClk,
  output logic halfTick
);
  logic [14:0] cntFf, nxt_cnt;
  logic [5:0] fsCntFf, nxt_fsCnt;
  logic subDlyFf, tickFf, nxt_tick;
  logic [3:0] halfExp;
  logic [14:0] mask;
  logic subEdge, useFs;

  // ----------------------------------------------------------------
  // rate select
  // ----------------------------------------------------------------
  always_comb begin
    subEdge = subClk & ~subDlyFf;
    useFs = (clkSel == 3'h0) && (lowClockSel || lowSpeed);
    halfExp = (clkSel == 3'h0) ? (`SLOW_EXP_HALF + {3'h0, extraDiv}) :
      4'(`FAST_EXP_BASE - {1'b0, clkSel} + {3'h0, extraDiv});
    mask = 15'((16'h1 << halfExp) - 16'h1);
    nxt_cnt = cntFf + 15'h1;
    nxt_fsCnt = subEdge ? fsCntFf + 6'h1 : fsCntFf;
    if (clkSel >= `CLK_RSVD || (lowSpeed && clkSel != 3'h0)) begin
      nxt_tick = 1'b0; // no internal clock here
    end else if (useFs) begin
      nxt_tick = subEdge && fsCntFf == `FS_HALF_LAST;
    end else begin
      nxt_tick = (cntFf & mask) == mask;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cntFf <= 15'h0;
      fsCntFf <= 6'h0;
      subDlyFf <= 1'b0;
      tickFf <= 1'b0;
    end else begin
      cntFf <= nxt_cnt;
      fsCntFf <= nxt_fsCnt;
      subDlyFf <= subClk;
      tickFf <= nxt_tick;
    end
  end

  assign halfTick = tickFf;
endmodule

//--- hw/sync_serial_buffered_port.sv
// buffered synchronous serial port: registers, buffer and shift engine
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/10ps
`include "sync_serial_defines.svh"
module sync_serial_buffered_port import sync_serial_pkg::*; (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic lowClockSel,
  input wire logic extraDiv,
  input wire logic lowSpeed,
  input wire logic subClk,
  input wire logic sclkIn,
  output logic sclkOut,
  output logic sclkOe,
  output logic serialOut,
  input wire logic serialIn,
  output logic bufferIrq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic runFf, abortFf, nxt_run, nxt_abort;
  logic [2:0] modeFf, sckFf, nxt_mode, nxt_sck;
  logic [1:0] waitFf, nxt_wait;
  logic [2:0] wordsFf, nxt_words;
  xfer_state_e stFf, nxt_st;
  logic [2:0] idxFf, bitFf, nxt_idx, nxt_bit;
  logic sclkFf, soFf, nxt_sclk, nxt_so;
  logic [7:0] rxFf, nxt_rx, rdataFf, nxt_rdata;
  logic [6:0] gapFf, nxt_gap;
  logic pendFf, activeFf, irqFf, nxt_pend, nxt_active, nxt_irq;
  logic sclkDlyFf;
  logic [7:0] bufMem [8];
  logic [7:0] nxt_buf [8];
  localparam logic [7:0] ctrlRst = `CTRL_RST; // named so reset values can be bit-selected

  logic tick, isExt, is4, isRx, isTx, fallEv, riseEv, bufHit, swAccess;
  logic ctrl1Wr, ctrl2Wr, lastWord, wordDone;
  logic [2:0] lastBit;
  logic [7:0] rxNew, txByte;

  serial_rate_gen rateGen (
    .mclk(mclk),
    .reset_n(reset_n),
    .clkSel(sckFf),
    .lowClockSel(lowClockSel),
    .extraDiv(extraDiv),
    .lowSpeed(lowSpeed),
    .subClk(subClk),
    .halfTick(tick)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  assign isExt = sckFf == `CLK_EXT;
  assign is4 = modeFf[1];
  assign isRx = modeFf[2];
  assign isTx = ~modeFf[0] & ~(modeFf[2] & modeFf[1]);
  assign lastBit = is4 ? `LAST_BIT4 : `LAST_BIT8;
  assign fallEv = isExt ? (sclkDlyFf & ~sclkIn) : (tick & sclkFf);
  assign riseEv = isExt ? (~sclkDlyFf & sclkIn) : (tick & ~sclkFf);
  assign bufHit = (addr & `BUF_MASK) == `BUF_BASE;
  assign swAccess = bufHit & (isRx ? rd : wr);
  assign ctrl1Wr = wr && addr == `ADDR_CTRL1;
  assign ctrl2Wr = wr && addr == `ADDR_CTRL2;
  assign txByte = isTx ? bufMem[idxFf] : 8'hff;
  assign wordDone = stFf == ST_SHIFT && riseEv && bitFf == lastBit;
  assign lastWord = wordDone && idxFf == wordsFf;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    rxNew = rxFf;
    rxNew[bitFf] = serialIn;
    nxt_run = runFf;
    nxt_abort = 1'b0; // clears once the abort has acted
    nxt_mode = modeFf;
    nxt_sck = sckFf;
    nxt_wait = waitFf;
    nxt_words = wordsFf; // only a software write changes it
    nxt_st = stFf;
    nxt_idx = idxFf;
    nxt_bit = bitFf;
    nxt_sclk = sclkFf;
    nxt_so = soFf;
    nxt_rx = rxFf;
    nxt_gap = gapFf;
    nxt_pend = pendFf & ~swAccess; // buffer access releases hold
    nxt_active = activeFf;
    nxt_irq = 1'b0;
    nxt_buf = bufMem;
    nxt_rdata = 8'h00;
    // register port
    if (ctrl1Wr) begin
      nxt_run = wdata[`RUN_POS];
      nxt_abort = wdata[`ABORT_POS];
      nxt_mode = wdata[`MODE_HI:`MODE_LO];
      nxt_sck = wdata[`CLK_HI:`CLK_LO];
    end
    if (ctrl2Wr) begin
      nxt_wait = wdata[`WAIT_HI:`WAIT_LO];
      nxt_words = wdata[`WORDS_HI:`WORDS_LO];
    end
    if (wr && bufHit) begin
      nxt_buf[addr[2:0]] = wdata;
    end
    if (rd) begin
      if (addr == `ADDR_STATUS) begin
        nxt_rdata = {activeFf, stFf == ST_SHIFT, 6'h00};
      end else if (bufHit) begin
        nxt_rdata = bufMem[addr[2:0]];
      end
    end
    // transfer engine
    unique case (stFf)
      ST_IDLE: begin
        nxt_sclk = 1'b1;
        if (ctrl1Wr && wdata[`RUN_POS] && !wdata[`ABORT_POS]) begin
          nxt_st = ST_SHIFT;
          nxt_active = 1'b1;
          nxt_idx = 3'h0;
          nxt_bit = 3'h0;
          nxt_pend = 1'b0;
        end
      end
      ST_SHIFT: begin
        if (fallEv) begin
          if (isExt && pendFf && bitFf == 3'h0) begin
            nxt_st = ST_IDLE; // software fell behind an outside clock
            nxt_active = 1'b0;
          end
          nxt_so = txByte[bitFf];
          if (!isExt) begin
            nxt_sclk = 1'b0;
          end
        end
        if (riseEv) begin
          if (!isExt) begin
            nxt_sclk = 1'b1;
          end
          nxt_rx = rxNew;
          nxt_bit = bitFf + 3'h1;
        end
        if (wordDone) begin
          nxt_bit = 3'h0;
          if (isRx) begin
            nxt_buf[idxFf] = is4 ? {4'h0, rxNew[3:0]} : rxNew;
          end
          nxt_idx = lastWord ? 3'h0 : idxFf + 3'h1;
          if (lastWord) begin
            nxt_irq = 1'b1;
            nxt_pend = 1'b1;
          end
          if (!runFf) begin
            nxt_st = ST_IDLE;
            nxt_active = 1'b0;
          end else if (!isExt && waitFf != 2'h0) begin
            nxt_st = ST_GAP;
            nxt_gap = 7'(((7'h1 << waitFf) - 7'h1) * `WORD_HALF_TICKS);
          end else if (!isExt && lastWord) begin
            nxt_st = ST_HOLD;
          end
        end
        // outside clock: burst done and run cleared ends the transfer
        if (isExt && pendFf && !runFf) begin
          nxt_st = ST_IDLE;
          nxt_active = 1'b0;
        end
      end
      ST_GAP: begin
        if (tick) begin
          nxt_gap = gapFf - 7'h1;
          if (gapFf == 7'h1) begin
            nxt_st = nxt_pend ? ST_HOLD : ST_SHIFT;
          end
        end
      end
      ST_HOLD: begin
        if (!runFf) begin
          nxt_st = ST_IDLE;
          nxt_active = 1'b0;
        end else if (!nxt_pend) begin
          nxt_st = ST_SHIFT;
        end
      end
    endcase
    if (ctrl1Wr && wdata[`ABORT_POS]) begin
      nxt_st = ST_IDLE;
      nxt_active = 1'b0;
      nxt_bit = 3'h0;
      nxt_idx = 3'h0;
      nxt_sclk = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      runFf <= ctrlRst[`RUN_POS];
      abortFf <= ctrlRst[`ABORT_POS];
      modeFf <= ctrlRst[`MODE_HI:`MODE_LO];
      sckFf <= ctrlRst[`CLK_HI:`CLK_LO];
      waitFf <= ctrlRst[`WAIT_HI:`WAIT_LO];
      wordsFf <= ctrlRst[`WORDS_HI:`WORDS_LO];
      stFf <= ST_IDLE;
      idxFf <= 3'h0;
      bitFf <= 3'h0;
      sclkFf <= 1'b1;
      soFf <= 1'b1;
      rxFf <= 8'h00;
      gapFf <= 7'h00;
      pendFf <= 1'b0;
      activeFf <= 1'b0;
      irqFf <= 1'b0;
      rdataFf <= 8'h00;
      sclkDlyFf <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        bufMem[i] <= 8'h00;
      end
    end else begin
      runFf <= nxt_run;
      abortFf <= nxt_abort;
      modeFf <= nxt_mode;
      sckFf <= nxt_sck;
      waitFf <= nxt_wait;
      wordsFf <= nxt_words;
      stFf <= nxt_st;
      idxFf <= nxt_idx;
      bitFf <= nxt_bit;
      sclkFf <= nxt_sclk;
      soFf <= nxt_so;
      rxFf <= nxt_rx;
      gapFf <= nxt_gap;
      pendFf <= nxt_pend;
      activeFf <= nxt_active;
      irqFf <= nxt_irq;
      rdataFf <= nxt_rdata;
      sclkDlyFf <= sclkIn;
      bufMem <= nxt_buf;
    end
  end

  // pin and port drive
  assign rdata = rdataFf;
  assign sclkOut = sclkFf;
  assign sclkOe = ~isExt;
  assign serialOut = soFf;
  assign bufferIrq = irqFf;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  status_read_a: assert property (
    rd && addr == `ADDR_STATUS |=> rdata[7] == $past(activeFf) && rdata[6] == ($past(stFf) == ST_SHIFT)
  ) else $error("status bits do not match engine state");
  abort_stop_a: assert property (
    ctrl1Wr && wdata[`ABORT_POS] |=> !activeFf && stFf == ST_IDLE ##1 !abortFf
  ) else $error("abort did not stop or self clear");
  start_flag_a: assert property (
    stFf == ST_IDLE && ctrl1Wr && wdata[`RUN_POS] && !wdata[`ABORT_POS] |=> activeFf && idxFf == 3'h0
  ) else $error("run did not start at lowest word");
  idle_high_a: assert property (
    stFf == ST_IDLE && !isExt |=> sclkOut
  ) else $error("internal clock not high when idle");
  hold_still_a: assert property (
    stFf == ST_HOLD ##1 stFf == ST_HOLD |-> $stable(sclkFf) && sclkFf
  ) else $error("clock moved during hold");
  lsb_out_a: assert property (
    stFf == ST_SHIFT && fallEv && !(isExt && pendFf) |=> serialOut == $past(txByte[bitFf])
  ) else $error("transmit bit not driven on falling edge");
  rx_sample_a: assert property (
    stFf == ST_SHIFT && riseEv |=> rxFf[$past(bitFf)] == $past(serialIn)
  ) else $error("receive bit not sampled on rising edge");
  nibble_zero_a: assert property (
    wordDone && isRx && is4 |=> bufMem[$past(idxFf)][7:4] == 4'h0
  ) else $error("upper nibble not cleared");
  irq_count_a: assert property (
    lastWord |=> bufferIrq ##1 !bufferIrq
  ) else $error("buffer interrupt missing after last word");
  words_kept_a: assert property (
    $fell(activeFf) && !$past(ctrl2Wr) |-> wordsFf == $past(wordsFf)
  ) else $error("word count changed at end of transfer");

  burst_end_c: cover property (lastWord ##1 bufferIrq);
  hold_seen_c: cover property (stFf == ST_HOLD ##1 stFf == ST_SHIFT);
  gap_seen_c: cover property (stFf == ST_GAP ##1 stFf == ST_SHIFT);
  abort_seen_c: cover property (stFf == ST_SHIFT ##1 abortFf);
  ext_burst_c: cover property (isExt && lastWord ##1 bufferIrq);
endmodule

//--- shared/sync_serial_defines.svh
// constants for the buffered synchronous serial port
// ----------------------------------------------------------------
// Contract
// - wait field picks frame time of 1, 2, 4 or 8 word times; 00 unless 8-bit tx/rx
// - word count field 000..111 moves 1..8 words from the lowest buffer byte upward
// - 4-bit words use the low nibble; received upper nibble is zero
// - send from lowest buffer address; store received words in ascending order
// - programmed word count survives the end of a transfer
// - status bit 7 shows transfer active, bit 6 shows shift active
// - with run cleared, transfer flag drops at word end, or at once on abort
// - clock code 111 takes the clock from the pin; 110 is reserved
// - internal codes give six fc or fs rates, extra prescale divides by two; here it divides only fc rates, fs rates ignore it
// - internal clock drives the pin; it idles and starts high
// - internal clock stops and holds until software writes or reads the buffer
// - transmit data changes on the falling edge of the serial clock
// - receive data is sampled on the rising edge of the serial clock
// - every word shifts least significant bit first
// - buffer interrupt rises when the programmed word count has moved
// - abort bit stops the transfer and clears itself afterwards
// ----------------------------------------------------------------
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH
`define ADDR_CTRL1 12'hfb4
`define ADDR_CTRL2 12'hfb5
`define ADDR_STATUS 12'hfb5
`define BUF_BASE 12'hf98
`define BUF_MASK 12'hff8
`define CTRL_RST 8'h00
`define RUN_POS 7
`define ABORT_POS 6
`define MODE_HI 5
`define MODE_LO 3
`define CLK_HI 2
`define CLK_LO 0
`define WAIT_HI 4
`define WAIT_LO 3
`define WORDS_HI 2
`define WORDS_LO 0
`define CLK_EXT 3'h7
`define CLK_RSVD 3'h6
`define LAST_BIT8 3'h7
`define LAST_BIT4 3'h3
`define WORD_HALF_TICKS 7'h10
`define SLOW_EXP_HALF 4'he
`define FAST_EXP_BASE 4'h8
`define FS_HALF_LAST 6'h3f
`endif

//--- shared/sync_serial_pkg.sv
// types for the buffered synchronous serial port
package sync_serial_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP, ST_HOLD} xfer_state_e;
endpackage

//--- sim/serial_peer.sv
// model of the external serial peripheral on the far side of the port
`timescale 1ns/10ps
module serial_peer (
  input wire logic mclk,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic load,
  input wire logic [15:0] loadVal,
  input wire logic burst,
  output logic sdi,
  output logic [15:0] cap,
  output logic extClk
);
  logic [3:0] divCnt = 4'h0;
  logic [4:0] edgesLeft = 5'h00;
  initial extClk = 1'b1;
  // ----------------------------------------
  // outside clock: one 8-bit burst per strobe, high when still
  // ----------------------------------------
  always @(posedge mclk) begin
    if (burst) begin
      edgesLeft <= 5'h10;
      divCnt <= 4'h0;
    end else if (edgesLeft != 5'h00) begin
      divCnt <= divCnt + 4'h1;
      if (divCnt == 4'h7) begin
        extClk <= ~extClk; // sixteen mclk per phase after an eight-mclk first phase, well above the minimum
        edgesLeft <= edgesLeft - 5'h01;
      end
    end
  end
  logic sclkPrev = 1'b1;
  logic [15:0] pat = 16'h0000;
  initial sdi = 1'b1;
  initial cap = 16'h0000;
  // ----------------------------------------
  // edge detect, drive on fall, capture on rise
  // ----------------------------------------
  always @(posedge mclk) begin
    sclkPrev <= sclk;
    if (load) begin
      pat <= loadVal;
    end else if (!sclk && sclkPrev) begin
      sdi <= pat[0];
      pat <= {~pat[0], pat[15:1]}; // refill keeps line moving
    end
    if (sclk && !sclkPrev) begin
      cap <= {sdo, cap[15:1]};
    end
  end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the buffered synchronous serial port
`timescale 1ns/10ps
`include "sync_serial_defines.svh"
module tb_top;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic load = 1'b0;
  logic [15:0] loadVal = 16'h0000;
  logic burst = 1'b0;
  logic extraDiv = 1'b0;
  logic lowClockSel = 1'b0;
  logic lowSpeed = 1'b0;
  logic subClk = 1'b0;
  logic extClk;
  logic [7:0] rdata;
  logic [7:0] rv;
  logic [15:0] cap;
  logic sclkOut, sclkOe, serialOut, serialIn, bufferIrq, sclkPin;
  int failures = 0;
  int n_checks = 0;
  // ----------------------------------------
  // clock, pin, design and peer
  // ----------------------------------------
  initial begin
    forever begin
      #10 mclk = ~mclk;
    end
  end
  // sub clock at half the main clock rate
  always @(posedge mclk) begin
    subClk <= ~subClk;
  end
  assign sclkPin = sclkOe ? sclkOut : extClk; // peer drives the pin when released, idles high
  sync_serial_buffered_port i_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .lowClockSel(lowClockSel), .extraDiv(extraDiv), .lowSpeed(lowSpeed),
    .subClk(subClk), .sclkIn(sclkPin), .sclkOut(sclkOut), .sclkOe(sclkOe), .serialOut(serialOut),
    .serialIn(serialIn), .bufferIrq(bufferIrq));
  serial_peer i_peer (.mclk(mclk), .sclk(sclkPin), .sdo(serialOut), .load(load),
    .loadVal(loadVal), .burst(burst), .sdi(serialIn), .cap(cap), .extClk(extClk));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wrReg(input logic [11:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rdReg(input logic [11:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic waitIrq();
    int i;
    for (i = 0; i < 3000 && bufferIrq !== 1'b1; i++) idle(1);
    if (bufferIrq !== 1'b1) begin
      failures++;
      $display("FAIL %0t no buffer interrupt", $time);
      summarize();
    end
  endtask
  // wait for a serial clock level, then count the mclk cycles it stands
  task automatic span(input logic lvl, output int n);
    int i;
    for (i = 0; i < 300 && sclkOut !== lvl; i++) idle(1);
    if (sclkOut !== lvl) begin
      failures++;
      $display("FAIL %0t serial clock stuck", $time);
      summarize();
    end
    for (n = 0; n < 300 && sclkOut === lvl; n++) idle(1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(sclkOut, 16'h1);
    chk(serialOut, 16'h1);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'h0);
    rdReg(12'h800, rv);
    chk(rv, 16'h0);
  endtask
  // tx8, two words at fc/2^4, hold, second burst, stop
  task automatic t_tx();
    wrReg(`ADDR_CTRL1, 8'h45);
    wrReg(`ADDR_CTRL2, 8'h01);
    wrReg(`BUF_BASE, 8'ha5);
    wrReg(12'hf99, 8'h3c);
    wrReg(`ADDR_CTRL1, 8'h85);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'hc0);
    waitIrq();
    idle(40);
    chk(cap, 16'h3ca5);
    chk(sclkOut, 16'h1);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'h80);
    wrReg(`BUF_BASE, 8'h96);
    wrReg(12'hf99, 8'h0f);
    waitIrq();
    idle(40);
    chk(cap, 16'h0f96);
    wrReg(`ADDR_CTRL1, 8'h05);
    idle(4);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'h0);
  endtask
  // rx4, one word, upper nibble cleared, then abort
  task automatic t_rx4();
    wrReg(`ADDR_CTRL1, 8'h75);
    wrReg(`ADDR_CTRL2, 8'h00);
    @(posedge mclk);
    load <= 1'b1;
    loadVal <= 16'hfffb;
    @(posedge mclk);
    load <= 1'b0;
    wrReg(`ADDR_CTRL1, 8'hb5);
    waitIrq();
    rdReg(`BUF_BASE, rv);
    chk(rv, 16'h0b);
    wrReg(`ADDR_CTRL1, 8'h75);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'h0);
  endtask
  // txrx8, two words, wait code 01 doubles the frame time
  task automatic t_gap();
    int n;
    wrReg(`ADDR_CTRL1, 8'h65);
    wrReg(`ADDR_CTRL2, 8'h09);
    wrReg(`BUF_BASE, 8'hc3);
    wrReg(12'hf99, 8'h81);
    @(posedge mclk);
    load <= 1'b1;
    loadVal <= 16'h1234;
    @(posedge mclk);
    load <= 1'b0;
    wrReg(`ADDR_CTRL1, 8'ha5);
    repeat (8) span(1'b0, n);
    span(1'b1, n);
    chk(n[15:0], 16'd136); // one half period plus sixteen idle half periods
    waitIrq();
    rdReg(`BUF_BASE, rv);
    chk(rv, 16'h34);
    rdReg(12'hf99, rv);
    chk(rv, 16'h12);
    chk(cap, 16'h81c3);
    wrReg(`ADDR_CTRL1, 8'h65);
  endtask
  // tx8 on the outside clock, one word, then run cleared
  task automatic t_ext();
    wrReg(`ADDR_CTRL1, 8'h47);
    wrReg(`ADDR_CTRL2, 8'h00);
    wrReg(`BUF_BASE, 8'h5a);
    wrReg(`ADDR_CTRL1, 8'h87);
    burst <= 1'b1;
    @(posedge mclk);
    burst <= 1'b0;
    waitIrq();
    idle(20);
    chk({8'h00, cap[15:8]}, 16'h005a);
    wrReg(`ADDR_CTRL1, 8'h07);
    idle(2);
    rdReg(`ADDR_STATUS, rv);
    chk(rv, 16'h0);
  endtask
  // clock source codes and the internal rates
  task automatic t_clk();
    int n;
    wrReg(`ADDR_CTRL1, 8'h47);
    idle(1);
    chk(sclkOe, 16'h0);
    wrReg(`ADDR_CTRL1, 8'h46);
    wrReg(`ADDR_CTRL1, 8'h86);
    idle(100);
    chk(sclkOut, 16'h1);
    wrReg(`ADDR_CTRL1, 8'h43);
    wrReg(`ADDR_CTRL1, 8'h83);
    span(1'b0, n);
    chk(n[15:0], 16'd32);
    wrReg(`ADDR_CTRL1, 8'h43);
    extraDiv <= 1'b1;
    wrReg(`ADDR_CTRL1, 8'h83);
    span(1'b0, n);
    chk(n[15:0], 16'd64); // extra divider halves the rate
    wrReg(`ADDR_CTRL1, 8'h40);
    lowClockSel <= 1'b1;
    wrReg(`ADDR_CTRL1, 8'h80);
    span(1'b0, n);
    chk(n[15:0], 16'd128); // sub clock runs at half of mclk
    wrReg(`ADDR_CTRL1, 8'h43);
    lowSpeed <= 1'b1;
    wrReg(`ADDR_CTRL1, 8'h83);
    idle(100);
    chk(sclkOut, 16'h1); // low-speed mode has no fast rates
    wrReg(`ADDR_CTRL1, 8'h43);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    t_reset();
    t_tx();
    t_rx4();
    t_gap();
    t_ext();
    t_clk();
    summarize();
  end
endmodule
